// ---- common/proxy_decode_params.svh ----
// offsets, field positions, reset values and timing for the proxy decoder
// assumes inclusion by bare name from the decoder module
`ifndef PROXY_DECODE_PARAMS_SVH
`define PROXY_DECODE_PARAMS_SVH

// address line codes {da2, da1, da0}
`define PXD_ADDR_FEAT_ERR 3'h1
`define PXD_ADDR_SECCNT 3'h2
`define PXD_ADDR_LBALO 3'h3
`define PXD_ADDR_LBAMID 3'h4
`define PXD_ADDR_DEVICE 3'h6
`define PXD_ADDR_DEVCTL 3'h6

// field positions
`define PXD_DEV_BIT 4
`define PXD_NIEN_BIT 1
`define PXD_SRST_BIT 2

// reset values and fixed read value
`define PXD_REG_RESET 8'h00
`define PXD_ZERO_READ 8'h00

// synchroniser depth in clock cycles
`define PXD_SYNC_STAGES 2

`endif

// ---- common/proxy_decode_pkg.sv ----
// types shared by the proxy task-file decoder
// assumes the params header sits on the include path
`default_nettype none

package proxy_decode_pkg;

  // decoded task-file target, one-hot
  typedef enum logic [6:0] {
    TGT_NONE = 7'h01,
    TGT_DEVCTL = 7'h02,
    TGT_FEAT_ERR = 7'h04,
    TGT_SECCNT = 7'h08,
    TGT_LBALO = 7'h10,
    TGT_LBAMID = 7'h20,
    TGT_DEVICE = 7'h40
  } tgt_t;

  // whole state of the decoder
  typedef struct packed {
    logic [7:0] devctl;
    logic [7:0] feature;
    logic [7:0] seccnt;
    logic [7:0] lbalo;
    logic [7:0] lbamid;
    logic dev;
    logic wr_prev;
    logic cap_cs0_n;
    logic cap_cs1_n;
    logic [2:0] cap_da;
    logic [7:0] cap_data;
    logic [7:0] dout;
    logic oe_n;
    logic bsy;
    logic drq;
  } state_t;

endpackage : proxy_decode_pkg

`default_nettype wire

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for a group of asynchronous pin levels
// assumes the pins are levels; bits may settle a cycle apart
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 15,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // refuse a group the flops cannot hold
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : pin_sync

`default_nettype wire

// ---- verilog/proxy_register_decode.sv ----
// device 0 task-file decode while answering for an absent device 1
// assumes async host pins, one 20 MHz clock, synchronous active-high reset
//
// Summary of operation
// - ignore unmapped accesses; busy and data-request read zero
// - control write stores interrupt-disable and soft reset
// - control-address read returns zero, never status
// - feature address write loads feature register
// - error address read drives error register
// - sector count write loads sector count
// - sector count read: contents, zero with packet set
// - lba low write loads lba low
// - lba low read: contents, zero with packet set
// - lba mid write loads lba mid
// - lba mid read returns contents without packet set
// - lba mid read returns zero with packet set
// - device select follows last written select bit
`timescale 1ns/1ns
`default_nettype none
`include "proxy_decode_params.svh"

module proxy_register_decode #(
  parameter bit PACKET_IMPL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs0_n,
  input wire logic i_cs1_n,
  input wire logic [2:0] i_da,
  input wire logic i_dior_n,
  input wire logic i_diow_n,
  input wire logic [7:0] i_dd,
  input wire logic [7:0] i_error,
  input wire logic i_dev1_absent,
  input wire logic i_busy,
  input wire logic i_data_req,
  output logic [7:0] o_dd,
  output logic o_dd_oe_n,
  output logic o_bsy,
  output logic o_drq,
  output logic o_proxy_active,
  output logic o_dev,
  output logic o_nien,
  output logic o_srst,
  output logic [7:0] o_feature,
  output logic [7:0] o_sector_count,
  output logic [7:0] o_lba_low,
  output logic [7:0] o_lba_mid
);

  proxy_decode_pkg::state_t st_q;
  proxy_decode_pkg::state_t st_d;
  logic [14:0] pins_s;
  logic cs0_s;
  logic cs1_s;
  logic [2:0] da_s;
  logic dior_s;
  logic diow_s;
  logic [7:0] dd_s;
  logic proxy;
  logic wr_commit;
  logic rd_low;
  proxy_decode_pkg::tgt_t wr_tgt;
  proxy_decode_pkg::tgt_t rd_tgt;

  // strobes reset negated, address lines reset low
  pin_sync #(
    .WIDTH(15),
    .RESET_VAL(15'h7800)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_cs0_n, i_cs1_n, i_dior_n, i_diow_n, i_da, i_dd}),
    .o_sync(pins_s)
  );

  assign cs0_s = pins_s[14];
  assign cs1_s = pins_s[13];
  assign dior_s = pins_s[12];
  assign diow_s = pins_s[11];
  assign da_s = pins_s[10:8];
  assign dd_s = pins_s[7:0];

  // chip selects and address lines to a task-file target
  function automatic proxy_decode_pkg::tgt_t decode(
    input logic cs0_n,
    input logic cs1_n,
    input logic [2:0] da
  );
    proxy_decode_pkg::tgt_t t;
    t = proxy_decode_pkg::TGT_NONE;
    if (cs0_n && !cs1_n && da == `PXD_ADDR_DEVCTL) begin
      t = proxy_decode_pkg::TGT_DEVCTL;
    end else if (!cs0_n && cs1_n) begin
      unique case (da)
        `PXD_ADDR_FEAT_ERR: t = proxy_decode_pkg::TGT_FEAT_ERR;
        `PXD_ADDR_SECCNT: t = proxy_decode_pkg::TGT_SECCNT;
        `PXD_ADDR_LBALO: t = proxy_decode_pkg::TGT_LBALO;
        `PXD_ADDR_LBAMID: t = proxy_decode_pkg::TGT_LBAMID;
        `PXD_ADDR_DEVICE: t = proxy_decode_pkg::TGT_DEVICE;
        default: t = proxy_decode_pkg::TGT_NONE;
      endcase
    end
    return t;
  endfunction : decode

  // contents unless the packet set hides them
  function automatic logic [7:0] hide(input logic [7:0] v);
    return PACKET_IMPL ? `PXD_ZERO_READ : v;
  endfunction : hide

  assign proxy = i_dev1_absent && st_q.dev;
  // a write lands at the trailing edge of the write strobe
  assign wr_commit = !st_q.wr_prev && diow_s;
  assign rd_low = !dior_s && diow_s;
  assign wr_tgt = decode(st_q.cap_cs0_n, st_q.cap_cs1_n, st_q.cap_da);
  assign rd_tgt = decode(cs0_s, cs1_s, da_s);

  always_comb begin
    st_d = st_q;
    st_d.wr_prev = diow_s;
    // hold address and data seen while the strobe was low
    if (!diow_s) begin
      st_d.cap_cs0_n = cs0_s;
      st_d.cap_cs1_n = cs1_s;
      st_d.cap_da = da_s;
      st_d.cap_data = dd_s;
    end
    if (wr_commit && wr_tgt == proxy_decode_pkg::TGT_DEVICE) begin
      st_d.dev = st_q.cap_data[`PXD_DEV_BIT];
    end
    if (wr_commit && proxy) begin
      unique case (wr_tgt)
        proxy_decode_pkg::TGT_DEVCTL: st_d.devctl = st_q.cap_data;
        proxy_decode_pkg::TGT_FEAT_ERR: st_d.feature = st_q.cap_data;
        proxy_decode_pkg::TGT_SECCNT: st_d.seccnt = st_q.cap_data;
        proxy_decode_pkg::TGT_LBALO: st_d.lbalo = st_q.cap_data;
        proxy_decode_pkg::TGT_LBAMID: st_d.lbamid = st_q.cap_data;
        proxy_decode_pkg::TGT_DEVICE, proxy_decode_pkg::TGT_NONE: begin
        end
      endcase
    end
    // read path; the device register read is left to the normal decode
    st_d.oe_n = 1'b1;
    st_d.dout = `PXD_ZERO_READ;
    if (proxy && rd_low) begin
      st_d.oe_n = 1'b0;
      unique case (rd_tgt)
        proxy_decode_pkg::TGT_DEVCTL: st_d.dout = `PXD_ZERO_READ;
        proxy_decode_pkg::TGT_FEAT_ERR: st_d.dout = i_error;
        proxy_decode_pkg::TGT_SECCNT: st_d.dout = hide(st_q.seccnt);
        proxy_decode_pkg::TGT_LBALO: st_d.dout = hide(st_q.lbalo);
        proxy_decode_pkg::TGT_LBAMID: st_d.dout = hide(st_q.lbamid);
        proxy_decode_pkg::TGT_DEVICE, proxy_decode_pkg::TGT_NONE: begin
          st_d.oe_n = 1'b1;
        end
      endcase
    end
    // nothing is busy on behalf of the missing device
    st_d.bsy = proxy ? 1'b0 : i_busy;
    st_d.drq = proxy ? 1'b0 : i_data_req;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '{devctl: `PXD_REG_RESET, feature: `PXD_REG_RESET,
                seccnt: `PXD_REG_RESET, lbalo: `PXD_REG_RESET,
                lbamid: `PXD_REG_RESET, dev: 1'b0, wr_prev: 1'b1,
                cap_cs0_n: 1'b1, cap_cs1_n: 1'b1, cap_da: 3'h0,
                cap_data: 8'h00, dout: 8'h00, oe_n: 1'b1,
                bsy: 1'b0, drq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_dd = st_q.dout;
  assign o_dd_oe_n = st_q.oe_n;
  assign o_bsy = st_q.bsy;
  assign o_drq = st_q.drq;
  assign o_proxy_active = proxy;
  assign o_dev = st_q.dev;
  assign o_nien = st_q.devctl[`PXD_NIEN_BIT];
  assign o_srst = st_q.devctl[`PXD_SRST_BIT];
  assign o_feature = st_q.feature;
  assign o_sector_count = st_q.seccnt;
  assign o_lba_low = st_q.lbalo;
  assign o_lba_mid = st_q.lbamid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_proxy_read(proxy_decode_pkg::tgt_t t);
    proxy && rd_low && rd_tgt == t;
  endsequence

  sequence s_proxy_write(proxy_decode_pkg::tgt_t t);
    wr_commit && proxy && wr_tgt == t;
  endsequence

  a_ignore_no_drive: assert property (
    s_proxy_read(proxy_decode_pkg::TGT_NONE) |=> o_dd_oe_n)
    else $error("unmapped proxy read drove the bus");
  a_status_zero: assert property (
    proxy ##1 proxy |-> !o_bsy && !o_drq)
    else $error("busy or data request set while proxying");
  a_devctl_write: assert property (
    s_proxy_write(proxy_decode_pkg::TGT_DEVCTL) |=>
    o_srst == $past(st_q.cap_data[`PXD_SRST_BIT]) &&
    o_nien == $past(st_q.cap_data[`PXD_NIEN_BIT]))
    else $error("control write not applied");
  a_devctl_read: assert property (
    s_proxy_read(proxy_decode_pkg::TGT_DEVCTL) |=> !o_dd_oe_n && o_dd == 8'h00)
    else $error("control read not zero");
  a_feature_write: assert property (
    s_proxy_write(proxy_decode_pkg::TGT_FEAT_ERR) |=>
    o_feature == $past(st_q.cap_data))
    else $error("feature not loaded");
  a_error_read: assert property (
    s_proxy_read(proxy_decode_pkg::TGT_FEAT_ERR) |=> o_dd == $past(i_error))
    else $error("error register not driven");
  a_seccnt_path: assert property (
    s_proxy_write(proxy_decode_pkg::TGT_SECCNT) |=>
    o_sector_count == $past(st_q.cap_data))
    else $error("sector count not loaded");
  a_seccnt_read: assert property (
    s_proxy_read(proxy_decode_pkg::TGT_SECCNT) |=>
    o_dd == (PACKET_IMPL ? 8'h00 : $past(st_q.seccnt)))
    else $error("sector count read wrong");
  a_lbalo_read: assert property (
    s_proxy_read(proxy_decode_pkg::TGT_LBALO) |=>
    o_dd == (PACKET_IMPL ? 8'h00 : $past(st_q.lbalo)))
    else $error("lba low read wrong");
  a_lbamid_read: assert property (
    s_proxy_read(proxy_decode_pkg::TGT_LBAMID) |=>
    o_dd == (PACKET_IMPL ? 8'h00 : $past(st_q.lbamid)))
    else $error("lba mid read wrong");
  a_dev_follow: assert property (
    wr_commit && wr_tgt == proxy_decode_pkg::TGT_DEVICE |=>
    o_dev == $past(st_q.cap_data[`PXD_DEV_BIT]))
    else $error("select bit not followed");
  a_proxy_gate: assert property (
    !proxy ##1 !proxy |-> o_dd_oe_n)
    else $error("bus driven outside proxy mode");

endmodule : proxy_register_decode

`default_nettype wire

// ---- verification/host_model.sv ----
// host adapter model driving the task-file pins
// assumes the device syncs the pins to i_clk
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_dev_dd,
  input wire logic i_dev_dd_oe_n,
  output logic o_cs0_n,
  output logic o_cs1_n,
  output logic [2:0] o_da,
  output logic o_dior_n,
  output logic o_diow_n,
  output logic [7:0] o_bus
);
  logic [7:0] wdata_q = 8'h00;
  logic wdrive_q = 1'b0;
  logic [7:0] last_q = 8'h00;

  initial begin
    o_cs0_n = 1'b1;
    o_cs1_n = 1'b1;
    o_da = 3'h0;
    o_dior_n = 1'b1;
    o_diow_n = 1'b1;
  end

  // undriven bus toggles so a stale value never reads as valid
  // an unknown enable before reset counts as released
  assign o_bus = (i_dev_dd_oe_n === 1'b0) ? i_dev_dd :
                 wdrive_q ? wdata_q : ~last_q;
  always @(posedge i_clk) last_q <= o_bus;

  // strobe low 5 clocks, address held 3 clocks past the rise
  task automatic cycle(input logic cs0_n, input logic cs1_n,
                       input logic [2:0] da, input logic wr,
                       input logic [7:0] data, output logic [7:0] rdata,
                       output logic oe_n);
    @(posedge i_clk);
    o_cs0_n <= cs0_n;
    o_cs1_n <= cs1_n;
    o_da <= da;
    wdata_q <= data;
    wdrive_q <= wr;
    @(posedge i_clk);
    if (wr) o_diow_n <= 1'b0;
    else o_dior_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    rdata = i_dev_dd;
    oe_n = i_dev_dd_oe_n;
    o_diow_n <= 1'b1;
    o_dior_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    wdrive_q <= 1'b0;
    o_cs0_n <= 1'b1;
    o_cs1_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask : cycle
endmodule : host_model

`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the proxy task-file decoder
// assumes host_model drives the pins; main instance without the packet feature set, twin with it
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic absent = 1'b0;
  logic busy = 1'b0;
  logic dreq = 1'b0;
  logic [7:0] err = 8'h00;
  logic cs0_n, cs1_n, dior_n, diow_n, oe_n, bsy, drq, act, dev, nien, srst;
  logic [2:0] da;
  logic [7:0] bus, dd, feat, sc, lo, mid, rv;
  logic ro;
  logic [7:0] pk_dd;
  logic pk_oe_n;
  logic [8:0] pk_q = 9'h1ff;
  int failures = 0;
  int checked = 0;

  initial forever #25 clk = ~clk;

  host_model host_model_inst (.i_clk(clk), .i_dev_dd(dd),
    .i_dev_dd_oe_n(oe_n), .o_cs0_n(cs0_n), .o_cs1_n(cs1_n), .o_da(da),
    .o_dior_n(dior_n), .o_diow_n(diow_n), .o_bus(bus));

  proxy_register_decode proxy_register_decode_inst (.i_clk(clk),
    .i_rst(rst), .i_cs0_n(cs0_n), .i_cs1_n(cs1_n), .i_da(da),
    .i_dior_n(dior_n), .i_diow_n(diow_n), .i_dd(bus), .i_error(err),
    .i_dev1_absent(absent), .i_busy(busy), .i_data_req(dreq), .o_dd(dd),
    .o_dd_oe_n(oe_n), .o_bsy(bsy), .o_drq(drq), .o_proxy_active(act),
    .o_dev(dev), .o_nien(nien), .o_srst(srst), .o_feature(feat),
    .o_sector_count(sc), .o_lba_low(lo), .o_lba_mid(mid));

  // packet-set twin on the same pins; it never drives the host bus
  proxy_register_decode #(
    .PACKET_IMPL(1'b1)
  ) proxy_register_decode_pkt_inst (.i_clk(clk), .i_rst(rst),
    .i_cs0_n(cs0_n), .i_cs1_n(cs1_n), .i_da(da), .i_dior_n(dior_n),
    .i_diow_n(diow_n), .i_dd(bus), .i_error(err),
    .i_dev1_absent(absent), .i_busy(busy), .i_data_req(dreq),
    .o_dd(pk_dd), .o_dd_oe_n(pk_oe_n), .o_bsy(), .o_drq(),
    .o_proxy_active(), .o_dev(), .o_nien(), .o_srst(), .o_feature(),
    .o_sector_count(), .o_lba_low(), .o_lba_mid());

  // keep the twin's last answer seen while the read strobe was low
  always @(posedge clk) begin
    if (!dior_n) begin
      pk_q <= {pk_oe_n, pk_dd};
    end
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic c0, input logic c1, input logic [2:0] a,
                    input logic [7:0] d);
    host_model_inst.cycle(c0, c1, a, 1'b1, d, rv, ro);
  endtask : wr

  task automatic rd(input logic c0, input logic c1, input logic [2:0] a);
    host_model_inst.cycle(c0, c1, a, 1'b0, 8'h00, rv, ro);
  endtask : rd

  task automatic t_reset;
    check("reset oe_n", 8'h01, {7'h00, oe_n});
    check("reset regs", 8'h00, feat | sc | lo | mid | {7'h00, dev});
    check("reset ctl", 8'h00, {6'h00, nien, srst});
  endtask : t_reset

  task automatic t_select;
    absent <= 1'b1;
    busy <= 1'b1;
    dreq <= 1'b1;
    wr(1'b0, 1'b1, 3'h6, 8'h10);
    check("dev", 8'h01, {7'h00, dev});
    check("proxy", 8'h01, {7'h00, act});
    check("bsy drq", 8'h00, {6'h00, bsy, drq});
  endtask : t_select

  task automatic t_regs;
    logic [7:0] v [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    logic [7:0] g;
    err <= 8'h5a;
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, 1'b1, 3'(i + 1), v[i]);
      g = i == 0 ? feat : i == 1 ? sc : i == 2 ? lo : mid;
      check("stored", v[i], g);
      rd(1'b0, 1'b1, 3'(i + 1));
      check("read", i == 0 ? 8'h5a : v[i], rv);
      check("read oe_n", 8'h00, {7'h00, ro});
      g = i == 0 ? 8'h5a : 8'h00;
      check("pkt read", g, pk_q[7:0]);
      check("pkt oe_n", 8'h00, {7'h00, pk_q[8]});
    end
  endtask : t_regs

  task automatic t_devctl;
    wr(1'b1, 1'b0, 3'h6, 8'h06);
    check("nien srst", 8'h03, {6'h00, nien, srst});
    rd(1'b1, 1'b0, 3'h6);
    check("ctl read", 8'h00, rv);
    check("ctl oe_n", 8'h00, {7'h00, ro});
    wr(1'b1, 1'b0, 3'h6, 8'h04);
    check("nien srst", 8'h01, {6'h00, nien, srst});
  endtask : t_devctl

  // bit 4 clear, so a stray select-register decode would drop proxy mode
  task automatic t_ignored;
    logic [4:0] c [5] = '{5'h1e, 5'h10, 5'h15, 5'h17, 5'h08};
    for (int i = 0; i < 5; i++) begin
      wr(c[i][4], c[i][3], c[i][2:0], 8'hef);
      check("feat", 8'ha5, feat);
      check("sc", 8'h3c, sc);
      check("lo", 8'h81, lo);
      check("mid", 8'h7e, mid);
      check("ctl", 8'h01, {6'h00, nien, srst});
      check("dev", 8'h01, {7'h00, dev});
      rd(c[i][4], c[i][3], c[i][2:0]);
      check("ignored oe_n", 8'h01, {7'h00, ro});
      check("pkt ignored", 8'h01, {7'h00, pk_q[8]});
      check("bsy drq", 8'h00, {6'h00, bsy, drq});
    end
  endtask : t_ignored

  task automatic t_normal;
    absent <= 1'b0;
    wr(1'b0, 1'b1, 3'h2, 8'h99);
    check("proxy", 8'h00, {7'h00, act});
    check("sc kept", 8'h3c, sc);
    check("bsy drq", 8'h03, {6'h00, bsy, drq});
    rd(1'b0, 1'b1, 3'h2);
    check("normal oe_n", 8'h01, {7'h00, ro});
    wr(1'b0, 1'b1, 3'h6, 8'h00);
    check("dev", 8'h00, {7'h00, dev});
  endtask : t_normal

  // mid-run reset, then a select write whose pins change on the second edge after release
  task automatic t_rereset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    wr(1'b0, 1'b1, 3'h6, 8'h10);
    check("dev", 8'h01, {7'h00, dev});
  endtask : t_rereset

  task automatic results;
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // about 30 bus cycles of 13 clocks each; wait fifteen times that
  initial begin
    #300000;
    failures++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_select();
    t_regs();
    t_devctl();
    t_ignored();
    t_normal();
    t_rereset();
    results();
  end
endmodule : tb

`default_nettype wire
